// File: verilog/lfcr_pkg.sv
// What this block does
// - High and low bytes join into 16-bit coefficient
// - Each coefficient is signed two's complement
// - Effects D4 resets to 0x7d high, 0x83 low
// - Effects D5 resets to 0x84 high, 0xee low
// - De-emphasis N0 resets to 0x39 high, 0x55 low
// - De-emphasis N1 resets to 0xf3 high, 0x2d low
// - De-emphasis D1 high byte resets to 0x53
// - De-emphasis D1 low byte resets to 0x7e
`default_nettype none
package lfcr_pkg;
   localparam int LFCR_NUM    = 5;
   localparam int LFCR_ADDR_W = 10;
   localparam int LFCR_DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [7:0] LFCR_IDX_D4_HIGH = 8'h11;
   localparam logic [7:0] LFCR_IDX_D4_LOW  = 8'h12;
   localparam logic [7:0] LFCR_IDX_D5_HIGH = 8'h13;
   localparam logic [7:0] LFCR_IDX_D5_LOW  = 8'h14;
   localparam logic [7:0] LFCR_IDX_N0_HIGH = 8'h15;
   localparam logic [7:0] LFCR_IDX_N0_LOW  = 8'h16;
   localparam logic [7:0] LFCR_IDX_N1_HIGH = 8'h17;
   localparam logic [7:0] LFCR_IDX_N1_LOW  = 8'h18;
   localparam logic [7:0] LFCR_IDX_D1_HIGH = 8'h19;
   localparam logic [7:0] LFCR_IDX_D1_LOW  = 8'h1a;
   localparam logic [7:0] LFCR_IDX_CTRL    = 8'h20;
   localparam logic [7:0] LFCR_IDX_STATUS  = 8'h21;

   localparam logic [7:0] LFCR_RST_D4_HIGH = 8'h7d;
   localparam logic [7:0] LFCR_RST_D4_LOW  = 8'h83;
   localparam logic [7:0] LFCR_RST_D5_HIGH = 8'h84;
   localparam logic [7:0] LFCR_RST_D5_LOW  = 8'hee;
   localparam logic [7:0] LFCR_RST_N0_HIGH = 8'h39;
   localparam logic [7:0] LFCR_RST_N0_LOW  = 8'h55;
   localparam logic [7:0] LFCR_RST_N1_HIGH = 8'hf3;
   localparam logic [7:0] LFCR_RST_N1_LOW  = 8'h2d;
   localparam logic [7:0] LFCR_RST_D1_HIGH = 8'h53;
   localparam logic [7:0] LFCR_RST_D1_LOW  = 8'h7e;
   localparam logic       LFCR_RST_HOLD    = 1'b0;

   localparam int LFCR_CTRL_HOLD_BIT   = 0;
   localparam int LFCR_STAT_PEND_BIT   = 0;
   localparam int LFCR_STAT_HOLD_BIT   = 1;

   // Entry order: 0 D4, 1 D5, 2 N0, 3 N1, 4 D1
   localparam logic [7:0] LFCR_HIGH_IDX [LFCR_NUM] = '{LFCR_IDX_D4_HIGH, LFCR_IDX_D5_HIGH,
      LFCR_IDX_N0_HIGH, LFCR_IDX_N1_HIGH, LFCR_IDX_D1_HIGH};
   localparam logic [7:0] LFCR_LOW_IDX  [LFCR_NUM] = '{LFCR_IDX_D4_LOW, LFCR_IDX_D5_LOW,
      LFCR_IDX_N0_LOW, LFCR_IDX_N1_LOW, LFCR_IDX_D1_LOW};
   localparam logic [7:0] LFCR_HIGH_RST [LFCR_NUM] = '{LFCR_RST_D4_HIGH, LFCR_RST_D5_HIGH,
      LFCR_RST_N0_HIGH, LFCR_RST_N1_HIGH, LFCR_RST_D1_HIGH};
   localparam logic [7:0] LFCR_LOW_RST  [LFCR_NUM] = '{LFCR_RST_D4_LOW, LFCR_RST_D5_LOW,
      LFCR_RST_N0_LOW, LFCR_RST_N1_LOW, LFCR_RST_D1_LOW};

   typedef logic signed [15:0] lfcr_coeff_t;

   typedef struct packed {
      lfcr_coeff_t d4;
      lfcr_coeff_t d5;
      lfcr_coeff_t n0;
      lfcr_coeff_t n1;
      lfcr_coeff_t d1;
   } lfcr_coeffs_t;
endpackage : lfcr_pkg
`default_nettype wire

// File: verilog/lfcr_coeff_pair.sv
`timescale 1ns/1ps
`default_nettype none
module lfcr_coeff_pair
   import lfcr_pkg::*;
#(
   parameter logic [7:0] HIGH_RESET = 8'h00,
   parameter logic [7:0] LOW_RESET  = 8'h00
) (
   input  wire logic       clk,
   input  wire logic       arst_n,
   input  wire logic       wr_high,
   input  wire logic       wr_low,
   input  wire logic [7:0] wdata,
   input  wire logic       hold,
   output logic [7:0]      high,
   output logic [7:0]      low,
   output lfcr_coeff_t     active
);
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         high <= HIGH_RESET;
      end else if (wr_high) begin
         high <= wdata;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         low <= LOW_RESET;
      end else if (wr_low) begin
         low <= wdata;
      end
   end

   // Copy lags one cycle so a half-written pair never reaches the filter while held
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         active <= {HIGH_RESET, LOW_RESET};
      end else if (!hold) begin
         active <= $signed({high, low});
      end
   end
endmodule : lfcr_coeff_pair
`default_nettype wire

// File: verilog/lfcr_top.sv
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module lfcr_top
   import lfcr_pkg::*;
(
   input  wire logic                   CLK,
   input  wire logic                   ARST_N,
   input  wire logic                   PSEL,
   input  wire logic                   PENABLE,
   input  wire logic                   PWRITE,
   input  wire logic [LFCR_ADDR_W-1:0] PADDR,
   input  wire logic [LFCR_DATA_W-1:0] PWDATA,
   input  wire logic [3:0]             PSTRB,
   output logic [LFCR_DATA_W-1:0]      PRDATA,
   output logic                        PREADY,
   output logic                        PSLVERR,
   output lfcr_coeffs_t                COEFFS
);
   logic [7:0]  word_idx;
   logic        aligned;
   logic        setup;
   logic        access;
   logic        wr_en;
   logic        hold_q;
   logic        pend_q;
   logic [7:0]  hi_q [LFCR_NUM];
   logic [7:0]  lo_q [LFCR_NUM];
   lfcr_coeff_t act  [LFCR_NUM];
   logic [LFCR_NUM-1:0] wr_hi;
   logic [LFCR_NUM-1:0] wr_lo;
   logic        coeff_wr;
   logic        ctrl_wr;
   logic [7:0]  next_rdata;
   logic        next_err;
   logic [LFCR_NUM-1:0] touched;
   logic [15:0] pair_d4;
   logic [15:0] pair_d5;
   logic [15:0] pair_n0;
   logic [15:0] pair_n1;
   logic [15:0] pair_d1;

   assign word_idx = PADDR[9:2];
   assign aligned  = (PADDR[1:0] == 2'h0);
   assign setup    = PSEL && !PENABLE;
   assign access   = PSEL && PENABLE;
   // Zero wait states: every access completes in its first access cycle
   assign PREADY   = 1'b1;
   // Byte lane 0 carries the whole 8-bit register; other lanes are ignored
   assign wr_en    = access && PWRITE && aligned && PSTRB[0];

   genvar g;
   generate
      for (g = 0; g < LFCR_NUM; g++) begin : g_pair
         assign wr_hi[g] = wr_en && (word_idx == LFCR_HIGH_IDX[g]);
         assign wr_lo[g] = wr_en && (word_idx == LFCR_LOW_IDX[g]);

         lfcr_coeff_pair #(
            .HIGH_RESET (LFCR_HIGH_RST[g]),
            .LOW_RESET  (LFCR_LOW_RST[g])
         ) u_pair (
            .clk     (CLK),
            .arst_n  (ARST_N),
            .wr_high (wr_hi[g]),
            .wr_low  (wr_lo[g]),
            .wdata   (PWDATA[7:0]),
            .hold    (hold_q),
            .high    (hi_q[g]),
            .low     (lo_q[g]),
            .active  (act[g])
         );

         // Helper for checks only: this pair has been written since reset
         always_ff @(posedge CLK or negedge ARST_N) begin
            if (!ARST_N) begin
               touched[g] <= 1'b0;
            end else if (wr_hi[g] || wr_lo[g]) begin
               touched[g] <= 1'b1;
            end
         end
      end
   endgenerate

   assign coeff_wr = |{wr_hi, wr_lo};
   assign ctrl_wr  = wr_en && (word_idx == LFCR_IDX_CTRL);

   assign COEFFS.d4 = act[0];
   assign COEFFS.d5 = act[1];
   assign COEFFS.n0 = act[2];
   assign COEFFS.n1 = act[3];
   assign COEFFS.d1 = act[4];

   assign pair_d4 = {hi_q[0], lo_q[0]};
   assign pair_d5 = {hi_q[1], lo_q[1]};
   assign pair_n0 = {hi_q[2], lo_q[2]};
   assign pair_n1 = {hi_q[3], lo_q[3]};
   assign pair_d1 = {hi_q[4], lo_q[4]};

   // Hold freezes the filter copy so software can update both bytes atomically
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         hold_q <= LFCR_RST_HOLD;
      end else if (ctrl_wr) begin
         hold_q <= PWDATA[LFCR_CTRL_HOLD_BIT];
      end
   end

   // Pending: a coefficient changed while held; releasing hold clears it, set wins
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         pend_q <= 1'b0;
      end else if (coeff_wr && hold_q) begin
         pend_q <= 1'b1;
      end else if (ctrl_wr && !PWDATA[LFCR_CTRL_HOLD_BIT]) begin
         pend_q <= 1'b0;
      end
   end

   always_comb begin
      next_rdata = 8'h00;
      next_err   = 1'b1;
      if (!aligned) begin
         next_err = 1'b1;
      end else if (word_idx == LFCR_IDX_CTRL) begin
         next_rdata[LFCR_CTRL_HOLD_BIT] = hold_q;
         next_err = 1'b0;
      end else if (word_idx == LFCR_IDX_STATUS) begin
         next_rdata[LFCR_STAT_PEND_BIT] = pend_q;
         next_rdata[LFCR_STAT_HOLD_BIT] = hold_q;
         next_err = 1'b0;
      end else begin
         for (int i = 0; i < LFCR_NUM; i++) begin
            if (word_idx == LFCR_HIGH_IDX[i]) begin
               next_rdata = hi_q[i];
               next_err   = 1'b0;
            end else if (word_idx == LFCR_LOW_IDX[i]) begin
               next_rdata = lo_q[i];
               next_err   = 1'b0;
            end
         end
      end
   end

   // Read data and error are captured in the setup cycle and stand through access
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PRDATA <= 32'h0000_0000;
      end else if (setup) begin
         PRDATA <= PWRITE ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      end
   end

   // Status is read-only, so writes to it are refused like unmapped ones
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         PSLVERR <= 1'b0;
      end else if (setup) begin
         PSLVERR <= next_err || (PWRITE && (word_idx == LFCR_IDX_STATUS));
      end
   end

   a_d4_reset : assert property (@(posedge CLK) disable iff (!ARST_N)
      !touched[0] |-> (hi_q[0] == 8'h7d) && (lo_q[0] == 8'h83))
      else $error("D4 pair lost its reset value");

   a_d5_reset : assert property (@(posedge CLK) disable iff (!ARST_N)
      !touched[1] |-> (pair_d5 == 16'h84ee))
      else $error("D5 pair lost its reset value");

   a_n0_reset : assert property (@(posedge CLK) disable iff (!ARST_N)
      !touched[2] |-> (pair_n0 == 16'h3955) && (COEFFS.n0 == 16'sh3955))
      else $error("N0 pair lost its reset value");

   a_n1_reset : assert property (@(posedge CLK) disable iff (!ARST_N)
      !touched[3] |-> (hi_q[3] == 8'hf3) && (lo_q[3] == 8'h2d))
      else $error("N1 pair lost its reset value");

   a_d1_high_reset : assert property (@(posedge CLK) disable iff (!ARST_N)
      !touched[4] |-> (hi_q[4] == 8'h53))
      else $error("D1 high byte lost its reset value");

   a_d1_low_reset : assert property (@(posedge CLK) disable iff (!ARST_N)
      !touched[4] |-> (lo_q[4] == 8'h7e) && (COEFFS.d1 == 16'sh537e))
      else $error("D1 low byte lost its reset value");

   a_pair_join : assert property (@(posedge CLK) disable iff (!ARST_N)
      $past(!hold_q) |-> (COEFFS.d4 == $past(pair_d4)) && (COEFFS.d1 == $past(pair_d1)))
      else $error("Filter coefficient does not match its byte pair");

   a_sign_kept : assert property (@(posedge CLK) disable iff (!ARST_N)
      $past(!hold_q) |-> ((COEFFS.d5 < 16'sh0000) == $past(hi_q[1][7])))
      else $error("Coefficient sign does not follow high byte bit 7");

   a_write_lands : assert property (@(posedge CLK) disable iff (!ARST_N)
      wr_hi[3] |=> (hi_q[3] == $past(PWDATA[7:0])))
      else $error("Write to N1 high byte not stored");

   a_read_back : assert property (@(posedge CLK) disable iff (!ARST_N)
      setup && !PWRITE && aligned && (word_idx == LFCR_IDX_N0_LOW)
      |=> (PRDATA == {24'h00_0000, $past(lo_q[2])}) && !PSLVERR)
      else $error("Read of N0 low byte returned wrong data");

   a_hold_freeze : assert property (@(posedge CLK) disable iff (!ARST_N)
      hold_q ##1 hold_q |-> $stable(COEFFS))
      else $error("Coefficients moved while held");

   a_unmapped_err : assert property (@(posedge CLK) disable iff (!ARST_N)
      setup && (word_idx == 8'h00) |=> PSLVERR && (PRDATA == 32'h0000_0000))
      else $error("Unmapped access not refused");

   a_ready_high : assert property (@(posedge CLK) disable iff (!ARST_N)
      PREADY)
      else $error("Ready dropped although no wait states exist");

   a_rdata_upper : assert property (@(posedge CLK) disable iff (!ARST_N)
      PRDATA[31:8] == 24'h00_0000)
      else $error("Read data upper lanes not zero");

   a_misalign_err : assert property (@(posedge CLK) disable iff (!ARST_N)
      setup && !aligned |=> PSLVERR && (PRDATA == 32'h0000_0000))
      else $error("Misaligned access not refused");

   a_status_wr_err : assert property (@(posedge CLK) disable iff (!ARST_N)
      setup && PWRITE && (word_idx == LFCR_IDX_STATUS) |=> PSLVERR)
      else $error("Write to status not refused");

   a_write_rdata : assert property (@(posedge CLK) disable iff (!ARST_N)
      setup && PWRITE |=> (PRDATA == 32'h0000_0000))
      else $error("Read data not zero on a write");

   a_rdata_stands : assert property (@(posedge CLK) disable iff (!ARST_N)
      !setup |=> $stable(PRDATA) && $stable(PSLVERR))
      else $error("Read data or error moved outside a setup cycle");

   a_hold_write : assert property (@(posedge CLK) disable iff (!ARST_N)
      ctrl_wr |=> (hold_q == $past(PWDATA[LFCR_CTRL_HOLD_BIT])))
      else $error("Hold bit not taken from control write");

   a_ctrl_read : assert property (@(posedge CLK) disable iff (!ARST_N)
      setup && !PWRITE && aligned && (word_idx == LFCR_IDX_CTRL)
      |=> (PRDATA == {31'h0000_0000, $past(hold_q)}) && !PSLVERR)
      else $error("Control read returned wrong data");

   a_status_read : assert property (@(posedge CLK) disable iff (!ARST_N)
      setup && !PWRITE && aligned && (word_idx == LFCR_IDX_STATUS)
      |=> (PRDATA == {30'h0000_0000, $past(hold_q), $past(pend_q)}) && !PSLVERR)
      else $error("Status read returned wrong data");

   a_pend_set : assert property (@(posedge CLK) disable iff (!ARST_N)
      coeff_wr && hold_q |=> pend_q)
      else $error("Pending not set by a held coefficient write");

   a_pend_clear : assert property (@(posedge CLK) disable iff (!ARST_N)
      ctrl_wr && !PWDATA[LFCR_CTRL_HOLD_BIT] |=> !pend_q)
      else $error("Pending not cleared on hold release");

   a_ctrl_quiet : assert property (@(posedge CLK) disable iff (!ARST_N)
      !coeff_wr && !ctrl_wr |=> $stable(pend_q) && $stable(hold_q))
      else $error("Control state moved without a write");

   // Refused and strobe-less writes must leave every byte alone
   a_strobe_ignored : assert property (@(posedge CLK) disable iff (!ARST_N)
      access && PWRITE && !PSTRB[0]
      |=> $stable({pair_d4, pair_d5, pair_n0, pair_n1, pair_d1}))
      else $error("Write without lane 0 strobe changed a register");

   a_misalign_keep : assert property (@(posedge CLK) disable iff (!ARST_N)
      access && PWRITE && !aligned
      |=> $stable({pair_d4, pair_d5, pair_n0, pair_n1, pair_d1}))
      else $error("Misaligned write changed a register");

   a_err_no_write : assert property (@(posedge CLK) disable iff (!ARST_N)
      access && PWRITE && PSLVERR
      |=> $stable({pair_d4, pair_d5, pair_n0, pair_n1, pair_d1}) && $stable(hold_q))
      else $error("Refused write changed state");

   generate
      for (g = 0; g < LFCR_NUM; g++) begin : g_chk
         a_high_read : assert property (@(posedge CLK) disable iff (!ARST_N)
            setup && !PWRITE && aligned && (word_idx == LFCR_HIGH_IDX[g])
            |=> (PRDATA == {24'h00_0000, $past(hi_q[g])}) && !PSLVERR)
            else $error("High byte read returned wrong data");

         a_low_read : assert property (@(posedge CLK) disable iff (!ARST_N)
            setup && !PWRITE && aligned && (word_idx == LFCR_LOW_IDX[g])
            |=> (PRDATA == {24'h00_0000, $past(lo_q[g])}) && !PSLVERR)
            else $error("Low byte read returned wrong data");

         a_high_write : assert property (@(posedge CLK) disable iff (!ARST_N)
            wr_hi[g] |=> (hi_q[g] == $past(PWDATA[7:0])))
            else $error("High byte write not stored");

         a_low_write : assert property (@(posedge CLK) disable iff (!ARST_N)
            wr_lo[g] |=> (lo_q[g] == $past(PWDATA[7:0])))
            else $error("Low byte write not stored");

         a_byte_kept : assert property (@(posedge CLK) disable iff (!ARST_N)
            !wr_hi[g] && !wr_lo[g] |=> $stable(hi_q[g]) && $stable(lo_q[g]))
            else $error("Byte changed without a write");

         a_copy_follow : assert property (@(posedge CLK) disable iff (!ARST_N)
            !hold_q |=> (act[g] == $past({hi_q[g], lo_q[g]})))
            else $error("Filter copy does not follow its byte pair");

         a_copy_held : assert property (@(posedge CLK) disable iff (!ARST_N)
            hold_q |=> $stable(act[g]))
            else $error("Filter copy moved while held");
      end
   endgenerate
endmodule : lfcr_top
`default_nettype wire

// File: dv/tb_left_filter_coeff_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_left_filter_coeff_regs
   import lfcr_pkg::*;
;
   typedef struct packed {
      logic [7:0] idx;
      logic [7:0] rst;
      logic [7:0] wv;
   } lfcr_row_t;

   // Register index, reset value, value written; d4 and d5 hit the signed extremes
   localparam lfcr_row_t ROWS [10] = '{
      '{8'h11, 8'h7d, 8'h80}, '{8'h12, 8'h83, 8'h00}, '{8'h13, 8'h84, 8'h7f},
      '{8'h14, 8'hee, 8'hff}, '{8'h15, 8'h39, 8'hc6}, '{8'h16, 8'h55, 8'haa},
      '{8'h17, 8'hf3, 8'h0c}, '{8'h18, 8'h2d, 8'hd2}, '{8'h19, 8'h53, 8'hac},
      '{8'h1a, 8'h7e, 8'h81}};

   logic                   clk     = 1'b0;
   logic                   arst_n  = 1'b0;
   logic                   psel    = 1'b0;
   logic                   penable = 1'b0;
   logic                   pwrite  = 1'b0;
   logic [LFCR_ADDR_W-1:0] paddr   = '0;
   logic [LFCR_DATA_W-1:0] pwdata  = '0;
   logic [3:0]             pstrb   = 4'h0;
   logic [LFCR_DATA_W-1:0] prdata;
   logic                   pready;
   logic                   pslverr;
   lfcr_coeffs_t           coeffs;
   int                     n_fail      = 0;
   int                     comparisons = 0;
   logic [79:0]            e;

   lfcr_top dut_u (
      .CLK     (clk),
      .ARST_N  (arst_n),
      .PSEL    (psel),
      .PENABLE (penable),
      .PWRITE  (pwrite),
      .PADDR   (paddr),
      .PWDATA  (pwdata),
      .PSTRB   (pstrb),
      .PRDATA  (prdata),
      .PREADY  (pready),
      .PSLVERR (pslverr),
      .COEFFS  (coeffs)
   );

   always #20 clk = ~clk;

   task automatic give_verdict;
      $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : give_verdict

   task automatic check(input logic [79:0] got, input logic [79:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : check

   // Upper lanes carry junk so that a design using them shows it
   task automatic apb(input logic w, input logic [7:0] idx, input logic [1:0] lsb,
                      input logic [7:0] d, input logic [3:0] s,
                      output logic [31:0] rd, output logic err);
      @(posedge clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= {idx, lsb};
      pwdata  <= {24'ha5a5a5, d};
      pstrb   <= s;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic rdc(input logic [7:0] idx, input logic [7:0] exp, input logic xerr);
      logic [31:0] rd;
      logic        err;
      apb(1'b0, idx, 2'b00, 8'h00, 4'h0, rd, err);
      check({47'h0, err, rd}, {47'h0, xerr, 24'h0, exp});
   endtask : rdc

   task automatic wrc(input logic [7:0] idx, input logic [1:0] lsb, input logic [7:0] d,
                      input logic [3:0] s, input logic xerr);
      logic [31:0] rd;
      logic        err;
      apb(1'b1, idx, lsb, d, s, rd, err);
      check({79'h0, err}, {79'h0, xerr});
   endtask : wrc

   // Filter copy moves one edge after the access edge
   task automatic settle;
      repeat (2) @(negedge clk);
   endtask : settle

   function automatic logic [79:0] pk(input bit sel);
      logic [79:0] v;
      v = '0;
      foreach (ROWS[i]) v = {v[71:0], sel ? ROWS[i].wv : ROWS[i].rst};
      return v;
   endfunction : pk

   initial begin
      repeat (8) @(posedge clk);
      check(coeffs, pk(1'b0));
      arst_n <= 1'b1;
      foreach (ROWS[i]) rdc(ROWS[i].idx, ROWS[i].rst, 1'b0);
      foreach (ROWS[i]) wrc(ROWS[i].idx, 2'b00, ROWS[i].wv, 4'hf, 1'b0);
      foreach (ROWS[i]) rdc(ROWS[i].idx, ROWS[i].wv, 1'b0);
      settle();
      check(coeffs, pk(1'b1));
      check({79'h0, coeffs.d4 < 0 && coeffs.d5 > 0}, 80'h1);
      // Refused and strobe-less accesses must leave the D4 bytes and status as they were
      rdc(8'h1b, 8'h00, 1'b1);
      rdc(8'h00, 8'h00, 1'b1);
      wrc(8'h11, 2'b01, 8'h00, 4'hf, 1'b1);
      wrc(8'h21, 2'b00, 8'h03, 4'hf, 1'b1);
      wrc(8'h12, 2'b00, 8'h55, 4'he, 1'b0);
      rdc(8'h11, 8'h80, 1'b0);
      rdc(8'h12, 8'h00, 1'b0);
      rdc(8'h21, 8'h00, 1'b0);
      // Hold freezes the filter copy while the register itself takes the write
      wrc(8'h20, 2'b00, 8'h01, 4'hf, 1'b0);
      wrc(8'h1a, 2'b00, 8'h11, 4'hf, 1'b0);
      settle();
      check(coeffs, pk(1'b1));
      rdc(8'h1a, 8'h11, 1'b0);
      rdc(8'h21, 8'h03, 1'b0);
      wrc(8'h20, 2'b00, 8'h00, 4'hf, 1'b0);
      settle();
      e = pk(1'b1);
      e[7:0] = 8'h11;
      check(coeffs, e);
      rdc(8'h21, 8'h00, 1'b0);
      // Second reset in mid-run
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      check(coeffs, pk(1'b0));
      arst_n <= 1'b1;
      rdc(8'h1a, 8'h7e, 1'b0);
      rdc(8'h11, 8'h7d, 1'b0);
      rdc(8'h20, 8'h00, 1'b0);
      give_verdict();
   end

   initial begin
      #100000;
      n_fail++;
      give_verdict();
   end
endmodule : tb_left_filter_coeff_regs
`default_nettype wire
